// ==== dv/mcs_sink.sv ====
// Far-end link model that takes outgoing messages, with stalls.
`timescale 1ns/1ps
`default_nettype none
module mcs_sink (
  // Clock.
  input  wire logic mclk,
  // Stall controls.
  input  wire logic stall,
  input  wire logic rnd,
  // Outgoing message handshake.
  output var  logic tx_ready
);
  int seed;
  // The far end reads no busy indication; congestion shows only as stalls.
  // It acts on no word that it takes, so every management message that
  // an older peer would not know is ignored there as well.
  initial begin
    seed = 32'h80a3;
    tx_ready = 1'b0;
    forever begin
      @(negedge mclk);
      tx_ready = stall ? 1'b0 : (rnd ? 1'($random(seed)) : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench of the message screening block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mcs_pkg::*;
;
  localparam int RPT = 2;
  logic        mclk, srst, is_stp, route_on_sio, opt_no_fc_old, link_inhibit;
  mcs_iss_t    peer_iss;
  logic [3:0]  link_272;
  logic        rx_valid, rx_ready, rx_local, cre_valid, cre_ready;
  logic        cre_need_ack, loc_valid, loc_ready, tx_valid, tx_ready;
  logic        rpt_valid, ovl_pulse, ign_pulse, busy_ind, ack_hold;
  logic        tco_active, chg_done, stall, rnd, leak;
  logic [63:0] rx_msg, cre_msg, loc_msg, tx_msg;
  logic [8:0]  rx_len, cre_len, tx_len;
  logic [1:0]  rx_link, cre_link, tx_link;
  logic [7:0]  cre_ack_h;
  logic [2:0]  rpt_code;
  logic [67:0] exp_q[$];
  logic [74:0] tx_q[$], tx_e;
  int          n_fail, total_checks, seed;

  mcs_screen #(
    .SI_MASK (16'h7FFF),
    .H0_MASK (16'h7FFF),
    .FLD_MASK(16'h7FFF),
    .ACK_CYC (16'h0008),
    .TCO_CYC (16'h000A),
    .MAX_RPT (3'(RPT))
  ) u_mcs_screen (
    .mclk, .srst, .is_stp, .route_on_sio, .peer_iss, .opt_no_fc_old,
    .link_272, .link_inhibit, .rx_valid, .rx_ready, .rx_local, .rx_msg,
    .rx_len, .rx_link, .cre_valid, .cre_ready, .cre_msg, .cre_len,
    .cre_link, .cre_need_ack, .cre_ack_h, .loc_valid, .loc_ready,
    .loc_msg, .tx_valid, .tx_ready, .tx_msg, .tx_len, .tx_link,
    .rpt_valid, .rpt_code, .ovl_pulse, .ign_pulse, .busy_ind, .ack_hold,
    .tco_active, .chg_done
  );
  mcs_sink u_mcs_sink (.mclk, .stall, .rnd, .tx_ready);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Every result must have been announced; an unexpected one hits 68'h0.
  task automatic note(input logic [3:0] k, input logic [63:0] v);
    if (exp_q.size() == 0) check({k, v}, 68'h0);
    else check({k, v}, exp_q.pop_front());
  endtask

  always @(posedge mclk) begin
    if (!srst) begin
      if (tx_valid && tx_ready) begin
        if (tx_q.size() == 0) check({4'h1, tx_msg}, 68'h0);
        else begin
          tx_e = tx_q.pop_front();
          check({4'h1, tx_msg}, {4'h1, tx_e[63:0]});
          check({57'h0, tx_link, tx_len}, {57'h0, tx_e[74:64]});
        end
      end
      if (loc_valid && loc_ready) note(4'h2, loc_msg);
      if (rpt_valid) note(4'h3, {61'h0, rpt_code});
      if (ovl_pulse) note(4'h4, 64'h0);
      if (ign_pulse) note(4'h5, 64'h0);
    end
  end

  always @(negedge mclk) begin
    loc_ready <= rnd ? 1'($random(seed)) : 1'b1;
  end

  // Spare bit 20 is always set, the other spare bits are random, so that any use of them shows.
  function automatic logic [63:0] mk(input logic [3:0] si,
                                     input logic [7:0] h,
                                     input logic [3:0] f);
    logic [63:0] m;
    m = {$random(seed), $random(seed)};
    m[3:0] = si;
    m[15:8] = h;
    m[19:16] = f;
    m[20] = 1'b1;
    return m;
  endfunction

  // Leaves rx_valid high so that the next message can follow at once.
  task automatic go(input logic loc, input logic [3:0] si,
                    input logic [7:0] h, input logic [3:0] f,
                    input logic [8:0] len, input logic [1:0] lk,
                    input logic [3:0] k, input logic [2:0] code);
    logic [63:0] m;
    m = mk(si, h, f);
    if (k == 4'h1) tx_q.push_back({lk, len, m});
    else if (k != 4'h0) exp_q.push_back({k, k == 4'h2 ? m : {61'h0, code}});
    rx_valid = 1'b1;
    rx_local = loc;
    rx_msg = m;
    rx_len = len;
    rx_link = lk;
    for (int i = 0; i < 300 && !rx_ready; i++) @(negedge mclk);
    @(negedge mclk);
  endtask

  task automatic cre(input logic need, input logic [7:0] ah,
                     input logic [8:0] len, input logic [1:0] lk,
                     input logic [3:0] k, input int n);
    logic [63:0] m;
    m = mk(4'h3, 8'h24, 4'h2);
    cre_msg = m;
    m[23:20] = 4'h0;
    repeat (n) begin
      if (k == 4'h1) tx_q.push_back({lk, len, m});
      else exp_q.push_back({k, 64'h0});
    end
    cre_valid = 1'b1;
    cre_need_ack = need;
    cre_ack_h = ah;
    cre_len = len;
    cre_link = lk;
    for (int i = 0; i < 300 && !cre_ready; i++) @(negedge mclk);
    @(negedge mclk);
    cre_valid = 1'b0;
    @(negedge mclk);
  endtask

  task automatic drain;
    rx_valid = 1'b0;
    for (int i = 0; i < 400 && exp_q.size() + tx_q.size() > 0; i++) begin
      @(negedge mclk);
    end
    repeat (20) @(negedge mclk);
  endtask

  initial begin
    seed = 32'h80a3;
    {rx_valid, rx_local, cre_valid, cre_need_ack, link_inhibit} = 5'h00;
    {is_stp, route_on_sio, opt_no_fc_old, stall, rnd, leak} = 6'h00;
    {rx_msg, cre_msg, rx_len, cre_len, rx_link, cre_link} = 150'h0;
    cre_ack_h = 8'h00;
    peer_iss = ISS_CURRENT;
    link_272 = 4'h5;
    srst = 1'b1;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    is_stp = 1'b1;
    rnd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(1'b0, 4'(i), 8'h20, 4'h1, 9'h03E, 2'(i), 4'h1, 3'h0);
    end
    go(1'b0, 4'hF, 8'h20, 4'h1, 9'h03E, 2'h0, 4'h1, 3'h0);
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h03F, 2'h1, 4'h4, 3'h0);
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h03F, 2'h2, 4'h1, 3'h0);
    route_on_sio = 1'b1;
    go(1'b0, 4'hF, 8'h20, 4'h1, 9'h010, 2'h0, 4'h3, 3'h1);
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h010, 2'h3, 4'h1, 3'h0);
    go(1'b1, 4'h2, 8'h21, 4'h1, 9'h010, 2'h0, 4'h2, 3'h0);
    go(1'b1, 4'hF, 8'h21, 4'h1, 9'h010, 2'h0, 4'h3, 3'h1);
    go(1'b1, 4'h2, 8'h0F, 4'h1, 9'h010, 2'h0, 4'h3, 3'h2);
    go(1'b1, 4'h2, 8'h21, 4'hF, 9'h010, 2'h0, 4'h3, 3'h3);
    is_stp = 1'b0;
    go(1'b0, 4'h2, 8'h21, 4'h1, 9'h010, 2'h0, 4'h2, 3'h0);
    go(1'b0, 4'hF, 8'h21, 4'h1, 9'h010, 2'h0, 4'h3, 3'h1);
    is_stp = 1'b1;
    drain;
    peer_iss = ISS_OLDEST;
    go(1'b1, 4'h2, 8'h51, 4'h1, 9'h010, 2'h0, 4'h5, 3'h0);
    go(1'b1, 4'h2, 8'h52, 4'h1, 9'h010, 2'h0, 4'h5, 3'h0);
    drain;
    peer_iss = ISS_CURRENT;
    cre(1'b0, 8'h00, 9'h03E, 2'h1, 4'h1, 1);
    cre(1'b0, 8'h00, 9'h03F, 2'h1, 4'h4, 1);
    cre(1'b1, 8'h44, 9'h020, 2'h0, 4'h1, RPT + 1);
    exp_q.push_back({4'h3, 61'h0, 3'h4});
    drain;
    cre(1'b1, 8'h33, 9'h020, 2'h0, 4'h1, 1);
    go(1'b1, 4'h2, 8'h33, 4'h1, 9'h010, 2'h0, 4'h0, 3'h0);
    drain;
    rnd = 1'b0;
    stall = 1'b1;
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h010, 2'h0, 4'h1, 3'h0);
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h010, 2'h1, 4'h1, 3'h0);
    rx_valid = 1'b0;
    @(negedge mclk);
    check({66'h0, busy_ind, ack_hold}, 68'h3);
    peer_iss = ISS_OLDER;
    opt_no_fc_old = 1'b1;
    @(negedge mclk);
    check({66'h0, busy_ind, ack_hold}, 68'h0);
    stall = 1'b0;
    drain;
    opt_no_fc_old = 1'b0;
    peer_iss = ISS_CURRENT;
    link_inhibit = 1'b1;
    @(negedge mclk);
    check({67'h0, tco_active}, 68'h1);
    go(1'b0, 4'h1, 8'h20, 4'h1, 9'h010, 2'h0, 4'h1, 3'h0);
    rx_valid = 1'b0;
    for (int i = 0; i < 60 && !chg_done; i++) begin
      @(negedge mclk);
      leak = leak | (tx_valid & tco_active);
    end
    check({66'h0, leak, chg_done}, 68'h1);
    link_inhibit = 1'b0;
    drain;
    end_of_test;
  end

  // The sequence needs well under a thousand cycles; five thousand is slack.
  initial begin
    #(50 * 5000);
    n_fail++;
    end_of_test;
  end
endmodule
`default_nettype wire

// ==== include/mcs_params.svh ====
// Constants of the message screening and compatibility block.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
`define MCS_MSG_W 64
`define MCS_LEN_W 9
`define MCS_LINK_W 2
`define MCS_NLINK 4
`define MCS_ENT_W 75
`define MCS_TMR_W 16
`define MCS_TRY_W 3
`define MCS_DEPTH 2'h2
`define MCS_SIO_LO 0
`define MCS_SI_HI 3
`define MCS_H_LO 8
`define MCS_H0_HI 11
`define MCS_H_HI 15
`define MCS_FLD_LO 16
`define MCS_FLD_HI 19
`define MCS_SPR_LO 20
`define MCS_SPR_HI 23
`define MCS_SHORT_SIF 9'h03E
`define MCS_H_TAA 8'h51
`define MCS_H_TPA 8'h52
`define MCS_RPT_SIO 3'h1
`define MCS_RPT_HDR 3'h2
`define MCS_RPT_FLD 3'h3
`define MCS_RPT_RTX 3'h4
`endif

// ==== include/mcs_pkg.sv ====
// Types of the message screening and compatibility block.
`include "mcs_params.svh"
package mcs_pkg;
  typedef enum logic [1:0] {ISS_OLDEST, ISS_OLDER, ISS_CURRENT} mcs_iss_t;
  typedef enum logic {TCO_IDLE, TCO_WAIT} mcs_tco_t;
  typedef struct packed {
    logic [1:0][`MCS_ENT_W-1:0] buf_q;
    logic                       wp;
    logic                       rp;
    logic [1:0]                 cnt;
    logic                       loc_v;
    logic [`MCS_MSG_W-1:0]      loc_msg;
    logic                       pend;
    logic [`MCS_ENT_W-1:0]      pend_e;
    logic [7:0]                 pend_ack;
    logic [`MCS_TMR_W-1:0]      ack_tmr;
    logic [`MCS_TRY_W-1:0]      tries;
    logic                       rpt_v;
    logic [2:0]                 rpt_code;
    logic                       ovl;
    logic                       ign;
    mcs_tco_t                   tco;
    logic [`MCS_TMR_W-1:0]      tco_tmr;
    logic                       inh_d;
    logic                       chg_done;
  } mcs_st_t;
endpackage

// ==== rtl/mcs_screen.sv ====
// Message screening, spare handling, repeat control and length guard.
`timescale 1ns/1ps
`default_nettype none
module mcs_screen
  import mcs_pkg::*;
#(
  parameter logic [15:0]           SI_MASK  = 16'hFFFF,
  parameter logic [15:0]           H0_MASK  = 16'hFFFF,
  parameter logic [15:0]           FLD_MASK = 16'hFFFF,
  parameter logic [`MCS_TMR_W-1:0] ACK_CYC  = 16'h4E20,
  parameter logic [`MCS_TMR_W-1:0] TCO_CYC  = 16'h3E80,
  parameter logic [`MCS_TRY_W-1:0] MAX_RPT  = 3'h2
) (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // Node configuration.
  input  wire logic                   is_stp,
  input  wire logic                   route_on_sio,
  input  wire mcs_iss_t               peer_iss,
  input  wire logic                   opt_no_fc_old,
  input  wire logic [`MCS_NLINK-1:0]  link_272,
  input  wire logic                   link_inhibit,
  // Received messages.
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  input  wire logic                   rx_local,
  input  wire logic [`MCS_MSG_W-1:0]  rx_msg,
  input  wire logic [`MCS_LEN_W-1:0]  rx_len,
  input  wire logic [`MCS_LINK_W-1:0] rx_link,
  // Locally created messages.
  input  wire logic                   cre_valid,
  output logic                        cre_ready,
  input  wire logic [`MCS_MSG_W-1:0]  cre_msg,
  input  wire logic [`MCS_LEN_W-1:0]  cre_len,
  input  wire logic [`MCS_LINK_W-1:0] cre_link,
  input  wire logic                   cre_need_ack,
  input  wire logic [7:0]             cre_ack_h,
  // Delivery to the owning functions.
  output logic                        loc_valid,
  input  wire logic                   loc_ready,
  output logic [`MCS_MSG_W-1:0]       loc_msg,
  // Outgoing messages.
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output logic [`MCS_MSG_W-1:0]       tx_msg,
  output logic [`MCS_LEN_W-1:0]       tx_len,
  output logic [`MCS_LINK_W-1:0]      tx_link,
  // Management and link status.
  output logic                        rpt_valid,
  output logic [2:0]                  rpt_code,
  output logic                        ovl_pulse,
  output logic                        ign_pulse,
  output logic                        busy_ind,
  output logic                        ack_hold,
  output logic                        tco_active,
  output logic                        chg_done
);

  mcs_st_t s;
  mcs_st_t n;

  function automatic logic bit_set(input logic [15:0] m,
                                   input logic [3:0] i);
    return m[i];
  endfunction

  function automatic logic len_ok(input logic [`MCS_LEN_W-1:0] l,
                                  input logic cap);
    return (l <= `MCS_SHORT_SIF) || cap;
  endfunction

  logic                  room;
  logic                  rtx_due;
  logic                  rx_fire;
  logic                  cre_fire;
  logic                  pop;
  logic [`MCS_ENT_W-1:0] head;
  logic                  sio_bad;
  logic                  hdr_bad;
  logic                  fld_bad;
  logic                  old_ack;
  logic                  rx_fit;
  logic                  cre_fit;
  logic [`MCS_MSG_W-1:0] cre_clean;

  // Spare bits are never looked at on receipt, only the coded fields.
  assign sio_bad = !bit_set(SI_MASK,
                   rx_msg[`MCS_SI_HI:`MCS_SIO_LO]);
  assign hdr_bad = !bit_set(H0_MASK, rx_msg[`MCS_H0_HI:`MCS_H_LO]);
  assign fld_bad = !bit_set(FLD_MASK,
                   rx_msg[`MCS_FLD_HI:`MCS_FLD_LO]);
  assign old_ack = (peer_iss == ISS_OLDEST) &&
                   (rx_msg[`MCS_H_HI:`MCS_H_LO] == `MCS_H_TAA ||
                    rx_msg[`MCS_H_HI:`MCS_H_LO] == `MCS_H_TPA);
  assign rx_fit  = len_ok(rx_len, link_272[rx_link]);
  assign cre_fit = len_ok(cre_len, link_272[cre_link]);

  always_comb begin
    cre_clean = cre_msg;
    cre_clean[`MCS_SPR_HI:`MCS_SPR_LO] = '0;
  end

  assign room     = s.cnt != `MCS_DEPTH;
  assign rtx_due  = s.pend && (s.ack_tmr == '0);
  assign rx_ready = room && !s.loc_v && !rtx_due && !cre_valid;
  assign cre_ready = room && !rtx_due && !(cre_need_ack && s.pend);
  assign rx_fire  = rx_valid && rx_ready;
  assign cre_fire = cre_valid && cre_ready;
  assign head     = s.buf_q[s.rp];
  // Traffic is held in the buffer while a changeover is running.
  assign tx_valid = (s.cnt != 2'h0) && (s.tco == TCO_IDLE);
  assign pop      = tx_valid && tx_ready;
  assign tx_msg   = head[`MCS_MSG_W-1:0];
  assign tx_len   = head[`MCS_MSG_W+`MCS_LEN_W-1:`MCS_MSG_W];
  assign tx_link  = head[`MCS_ENT_W-1:`MCS_MSG_W+`MCS_LEN_W];
  assign loc_valid = s.loc_v;
  assign loc_msg   = s.loc_msg;
  assign rpt_valid = s.rpt_v;
  assign rpt_code  = s.rpt_code;
  assign ovl_pulse = s.ovl;
  assign ign_pulse = s.ign;
  assign tco_active = s.tco == TCO_WAIT;
  assign chg_done  = s.chg_done;
  // A full buffer is congestion; the option spares older peers.
  assign busy_ind = !room &&
         !(opt_no_fc_old && peer_iss != ISS_CURRENT);
  assign ack_hold = busy_ind;

  always_comb begin
    logic                  push;
    logic [`MCS_ENT_W-1:0] push_e;
    push   = 1'b0;
    push_e = '0;
    n = s;
    n.rpt_v    = 1'b0;
    n.ovl      = 1'b0;
    n.ign      = 1'b0;
    n.chg_done = 1'b0;
    n.inh_d    = link_inhibit;
    if (s.loc_v && loc_ready) begin
      n.loc_v = 1'b0;
    end
    if (s.pend && s.ack_tmr != '0) begin
      n.ack_tmr = s.ack_tmr - 1'b1;
    end
    if (rtx_due) begin
      if (s.tries < MAX_RPT) begin
        if (room) begin
          push      = 1'b1;
          push_e    = s.pend_e;
          n.tries   = s.tries + 1'b1;
          n.ack_tmr = ACK_CYC;
        end
      end else begin
        // Give up rather than repeat without end.
        n.pend     = 1'b0;
        n.rpt_v    = 1'b1;
        n.rpt_code = `MCS_RPT_RTX;
      end
    end else if (rx_fire) begin
      if (!rx_local && is_stp) begin
        if (route_on_sio && sio_bad) begin
          n.rpt_v    = 1'b1;
          n.rpt_code = `MCS_RPT_SIO;
        end else if (!rx_fit) begin
          n.ovl = 1'b1;
        end else begin
          push   = 1'b1;
          push_e = {rx_link, rx_len, rx_msg};
        end
      end else if (sio_bad) begin
        n.rpt_v    = 1'b1;
        n.rpt_code = `MCS_RPT_SIO;
      end else if (hdr_bad) begin
        n.rpt_v    = 1'b1;
        n.rpt_code = `MCS_RPT_HDR;
      end else if (fld_bad) begin
        n.rpt_v    = 1'b1;
        n.rpt_code = `MCS_RPT_FLD;
      end else if (old_ack) begin
        n.ign = 1'b1;
      end else if (s.pend &&
                   rx_msg[`MCS_H_HI:`MCS_H_LO] == s.pend_ack) begin
        n.pend = 1'b0;
      end else begin
        n.loc_v   = 1'b1;
        n.loc_msg = rx_msg;
      end
    end else if (cre_fire) begin
      if (!cre_fit) begin
        n.ovl = 1'b1;
      end else begin
        push   = 1'b1;
        push_e = {cre_link, cre_len, cre_clean};
        if (cre_need_ack) begin
          n.pend     = 1'b1;
          n.pend_e   = push_e;
          n.pend_ack = cre_ack_h;
          n.ack_tmr  = ACK_CYC;
          n.tries    = '0;
        end
      end
    end
    if (push) begin
      n.buf_q[s.wp] = push_e;
      n.wp = ~s.wp;
    end
    if (pop) begin
      n.rp = ~s.rp;
    end
    n.cnt = s.cnt + 2'(push) - 2'(pop);
    case (s.tco)
      TCO_IDLE: begin
        if (link_inhibit && !s.inh_d) begin
          n.tco     = TCO_WAIT;
          n.tco_tmr = TCO_CYC;
        end
      end
      TCO_WAIT: begin
        if (s.tco_tmr == '0) begin
          n.tco      = TCO_IDLE;
          n.chg_done = 1'b1;
        end else begin
          n.tco_tmr = s.tco_tmr - 1'b1;
        end
      end
      default: n.tco = TCO_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  chk_sio_drop: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && sio_bad && !rtx_due |=>
      rpt_valid && rpt_code == `MCS_RPT_SIO && !$rose(loc_valid))
    else $error("Unallocated service indicator not dropped.");

  chk_hdr_drop: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && !sio_bad && hdr_bad |=>
      rpt_valid && rpt_code == `MCS_RPT_HDR && !loc_valid)
    else $error("Unallocated heading code not dropped.");

  chk_fld_drop: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && !sio_bad && !hdr_bad && fld_bad |=>
      rpt_valid && rpt_code == `MCS_RPT_FLD && !loc_valid)
    else $error("Unallocated field value not dropped.");

  chk_spare_zero: assert property (@(posedge mclk) disable iff (srst)
    cre_fire && cre_fit && s.cnt == 2'h0 |=>
      tx_msg[`MCS_SPR_HI:`MCS_SPR_LO] == '0 && tx_len == $past(cre_len))
    else $error("Created message has nonzero spare bits.");

  chk_transit_same: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && !rx_local && is_stp && !route_on_sio && rx_fit &&
    s.cnt == 2'h0 |=> tx_msg == $past(rx_msg) &&
      tx_len == $past(rx_len) && tx_valid != tco_active)
    else $error("Transit message altered.");

  chk_repeat_sent: assert property (@(posedge mclk) disable iff (srst)
    rtx_due && s.tries < MAX_RPT && room |=>
      s.tries == $past(s.tries) + 1'b1 && s.ack_tmr == ACK_CYC &&
      s.cnt != 2'h0)
    else $error("Missing acknowledgement not repeated.");

  chk_repeat_bound: assert property (@(posedge mclk) disable iff (srst)
    rtx_due && s.tries == MAX_RPT |=>
      !s.pend && rpt_valid && rpt_code == `MCS_RPT_RTX)
    else $error("Repeats exceed the limit.");

  chk_busy_ind: assert property (@(posedge mclk) disable iff (srst)
    s.cnt == `MCS_DEPTH && peer_iss == ISS_CURRENT |-> busy_ind && ack_hold)
    else $error("Congestion not signalled.");

  chk_old_ack: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && !sio_bad && !hdr_bad && !fld_bad && old_ack
    |=> ign_pulse && !loc_valid)
    else $error("Acknowledgement from oldest peer not ignored.");

  chk_overlength: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && !rx_local && is_stp && !route_on_sio && !rx_fit |=>
      ovl_pulse && s.cnt == $past(s.cnt) - 2'($past(pop)))
    else $error("Overlength message routed to short link.");

  chk_tco_hold: assert property (@(posedge mclk) disable iff (srst)
    s.tco == TCO_IDLE && link_inhibit && !s.inh_d |=>
      !tx_valid ##1 !tx_valid)
    else $error("Traffic not held during changeover.");

  chk_loc_deliver: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && !sio_bad && !hdr_bad && !fld_bad && !old_ack &&
    !s.pend |=>
      loc_valid && loc_msg == $past(rx_msg))
    else $error("Good local message not delivered unchanged.");

  chk_ack_clear: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && rx_local && !sio_bad && !hdr_bad && !fld_bad && !old_ack &&
    s.pend && rx_msg[`MCS_H_HI:`MCS_H_LO] == s.pend_ack |=>
      !s.pend && !loc_valid)
    else $error("Matching acknowledgement did not end the repeats.");

  chk_cre_overlen: assert property (@(posedge mclk) disable iff (srst)
    cre_fire && !cre_fit |=>
      ovl_pulse && s.cnt == $past(s.cnt) - 2'($past(pop)))
    else $error("Overlength created message not held back.");

  chk_transit_sio: assert property (@(posedge mclk) disable iff (srst)
    rx_fire && !rx_local && is_stp && route_on_sio && sio_bad |=>
      rpt_valid && rpt_code == `MCS_RPT_SIO &&
      s.cnt == $past(s.cnt) - 2'($past(pop)))
    else $error("Transit message with bad service indicator sent.");

  chk_no_fc_old: assert property (@(posedge mclk) disable iff (srst)
    opt_no_fc_old && peer_iss != ISS_CURRENT |-> !busy_ind && !ack_hold)
    else $error("Flow control triggered toward an older peer.");

  chk_tco_done: assert property (@(posedge mclk) disable iff (srst)
    s.tco == TCO_WAIT && s.tco_tmr == '0 |=>
      chg_done && !tco_active)
    else $error("Changeover did not end after its time.");

  chk_buf_bound: assert property (@(posedge mclk) disable iff (srst)
    s.cnt <= `MCS_DEPTH && (s.cnt != `MCS_DEPTH || !rx_ready && !cre_ready))
    else $error("Buffer overfilled or accepting while full.");

  chk_cre_pend: assert property (@(posedge mclk) disable iff (srst)
    cre_fire && cre_fit && cre_need_ack |=>
      s.pend && s.tries == '0 && s.ack_tmr == ACK_CYC &&
      s.pend_ack == $past(cre_ack_h))
    else $error("Acknowledged message not put under supervision.");

  chk_tco_start: assert property (@(posedge mclk) disable iff (srst)
    s.tco == TCO_IDLE && link_inhibit && !s.inh_d |=>
      tco_active && s.tco_tmr == TCO_CYC)
    else $error("Changeover not started by an inhibit.");

  chk_give_up_once: assert property (@(posedge mclk) disable iff (srst)
    rpt_valid && rpt_code == `MCS_RPT_RTX |-> !s.pend)
    else $error("Message still supervised after giving up.");

endmodule
`default_nettype wire
